// ### src/idb_dma_sig.sv
// Function
// - io strobes are driven during dma cycles and are inputs otherwise.
// - low-memory write strobe is always driven, low when a20..a23 and memory write are low.
// - low-memory read strobe is always driven, low when a20..a23 and memory read are low.
// - memory strobes are driven during dma cycles and sampled otherwise.
// - a configuration bit picks cache flush or extra local master grant for the shared pin.
// - with flush selected the cpu cache may be flushed each time hold is raised for speed.
// - with turbo selected a low turbo input means slow and high means fast.
// - the turbo input is ignored until speed control has been programmed.
// - with the alternate function the shared input is an extra local master request.
// - channels 0 to 3 are 8-bit and channels 5 to 7 are 16-bit.
// - terminal count is high during the last transfer cycle only.
// - address enable is high during dma and refresh cycles.
// - address enable is low when cpu, local master or isa master owns the bus.
// - an isa master pulls master low after its grant and address enable then goes low.
`timescale 1ns/1ps
`include "idb_regs.svh"
module idb_dma_sig
  import idb_pkg::*;
#(
  parameter int NCH = `IDB_NCH,
  parameter int CNT_W = `IDB_CNT_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // configuration
  input wire logic alt_sel,
  input wire logic perf_cfg_done,
  input wire logic flush_en,
  input wire logic [CNT_W-1:0] xfer_count,
  // dma channel requests and acknowledges
  input wire logic [NCH-1:0] dreq,
  output logic [NCH-1:0] dack_n,
  output logic tc,
  output logic aen,
  output logic xfer_16bit,
  // isa master and refresh
  input wire logic master_n,
  input wire logic refresh_req,
  // performance hold
  input wire logic perf_hold,
  output logic slow_req,
  // shared pins
  input wire logic slow_lreq_n,
  output logic flush_lgnt_n,
  output logic xreq,
  input wire logic xgnt,
  // io strobes
  input wire logic ior_n_i,
  output logic ior_n_o,
  output logic ior_n_oe,
  input wire logic iow_n_i,
  output logic iow_n_o,
  output logic iow_n_oe,
  // memory strobes
  input wire logic memr_n_i,
  output logic memr_n_o,
  output logic memr_n_oe,
  input wire logic memw_n_i,
  output logic memw_n_o,
  output logic memw_n_oe,
  input wire logic [`IDB_HI_ADDR_W-1:0] hi_addr,
  output logic smemr_n,
  output logic smemw_n,
  // io register access seen while not in dma
  output logic io_rd_q,
  output logic io_wr_q,
  // transfer direction: 1 = memory to io
  input wire logic dir_rd
);
  idb_state_t st_q;
  logic [2:0] ch_q;
  logic [CNT_W-1:0] cnt_q;
  logic flush_w;
  logic dma_act;

  function automatic logic [2:0] pick_ch(input logic [NCH-1:0] r);
    logic [2:0] c;
    c = 3'd0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (r[i] && i != `IDB_CH_CASCADE) begin
        c = 3'(i);
      end
    end
    return c;
  endfunction : pick_ch

  function automatic logic is_wide(input logic [2:0] c);
    return c > 3'(`IDB_CH_CASCADE);
  endfunction : is_wide

  logic [NCH-1:0] req_ok;
  assign req_ok = dreq & ~(NCH'(1) << `IDB_CH_CASCADE);
  assign dma_act = (st_q == IDB_XFER);

  // channel sequencer; an isa master may come through any channel but the cascade channel 4
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= IDB_IDLE;
      ch_q <= 3'd0;
      cnt_q <= '0;
    end else if (clk_en) begin
      case (st_q)
        IDB_IDLE: begin
          if (!refresh_req && |req_ok) begin
            ch_q <= pick_ch(req_ok);
            cnt_q <= xfer_count;
            st_q <= IDB_ACK;
          end
        end
        IDB_ACK: begin
          st_q <= !master_n ? IDB_MSTR : IDB_XFER;
        end
        IDB_XFER: begin
          if (!master_n) begin
            st_q <= IDB_MSTR;
          end else if (cnt_q == '0 || !dreq[ch_q]) begin
            st_q <= IDB_IDLE;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        IDB_MSTR: begin
          if (!dreq[ch_q]) begin
            st_q <= IDB_IDLE;
          end
        end
        default: begin
          st_q <= IDB_IDLE;
        end
      endcase
    end
  end

  // ack follows the sequencer state, held through the transfer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dack_n <= '1;
      xfer_16bit <= 1'b0;
    end else if (clk_en) begin
      dack_n <= '1;
      if (st_q == IDB_ACK || (st_q == IDB_XFER && !(cnt_q == '0 || !dreq[ch_q])) ||
          (st_q == IDB_MSTR && dreq[ch_q])) begin
        dack_n[ch_q] <= 1'b0;
      end
      xfer_16bit <= is_wide(ch_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tc <= 1'b0;
    end else if (clk_en) begin
      tc <= (st_q == IDB_XFER) && master_n && dreq[ch_q] && cnt_q == CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aen <= 1'b0;
    end else if (clk_en) begin
      // master low overrides even a pending dma or refresh
      aen <= master_n && (refresh_req || st_q == IDB_ACK || dma_act);
    end
  end

  // strobe direction follows dma ownership
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ior_n_oe <= 1'b0;
      iow_n_oe <= 1'b0;
      memr_n_oe <= 1'b0;
      memw_n_oe <= 1'b0;
      ior_n_o <= 1'b1;
      iow_n_o <= 1'b1;
      memr_n_o <= 1'b1;
      memw_n_o <= 1'b1;
    end else if (clk_en) begin
      ior_n_oe <= dma_act;
      iow_n_oe <= dma_act;
      memr_n_oe <= dma_act;
      memw_n_oe <= dma_act;
      ior_n_o <= !(dma_act && !dir_rd);
      iow_n_o <= !(dma_act && dir_rd);
      memr_n_o <= !(dma_act && dir_rd);
      memw_n_o <= !(dma_act && !dir_rd);
    end
  end

  // internal register access only when the strobes are inputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      io_rd_q <= 1'b0;
      io_wr_q <= 1'b0;
    end else if (clk_en) begin
      io_rd_q <= !ior_n_oe && !ior_n_i;
      io_wr_q <= !iow_n_oe && !iow_n_i;
    end
  end

  // shared pins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      xreq <= 1'b0;
      flush_lgnt_n <= 1'b1;
    end else if (clk_en) begin
      xreq <= alt_sel && !slow_lreq_n;
      flush_lgnt_n <= alt_sel ? !xgnt : flush_w;
    end
  end

  logic [3:0] mem_hi;
  logic mem_r;
  logic mem_w;
  // during dma the driven strobes feed the decode, otherwise the sampled ones
  assign mem_hi = hi_addr;
  assign mem_r = memr_n_oe ? memr_n_o : memr_n_i;
  assign mem_w = memw_n_oe ? memw_n_o : memw_n_i;

  idb_strobe u_strobe (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .hi_addr(mem_hi),
    .memw_n(mem_w),
    .memr_n(mem_r),
    .smemw_n(smemw_n),
    .smemr_n(smemr_n)
  );

  idb_speed u_speed (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .alt_sel(alt_sel),
    .perf_cfg_done(perf_cfg_done),
    .flush_en(flush_en),
    .slow_in(slow_lreq_n),
    .perf_hold(perf_hold),
    .slow_req(slow_req),
    .flush_n(flush_w)
  );

  a_aen_master: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && !master_n) |=> !aen)
    else $error("aen high while master low");
  a_aen_refresh: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && master_n && refresh_req) |=> aen)
    else $error("aen low in refresh");
  a_aen_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && st_q == IDB_IDLE && !refresh_req) |=> !aen)
    else $error("aen high while cpu owns bus");
  a_ack_granted: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && st_q == IDB_IDLE) |=> dack_n == '1)
    else $error("ack without grant");
  a_strobe_dir: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && st_q != IDB_XFER) |=> !ior_n_oe && !iow_n_oe)
    else $error("io strobes driven outside dma");
  a_mem_dir: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && dma_act) |=> memr_n_oe && memw_n_oe)
    else $error("memory strobes not driven in dma");
  a_tc_last: assert property (@(posedge mclk) disable iff (sys_rst)
    tc |-> $past(cnt_q) == CNT_W'(1))
    else $error("tc outside last cycle");
  a_wide_ch: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && ch_q >= 3'd5) |=> xfer_16bit)
    else $error("16-bit channel not wide");
  a_pin_sel: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && alt_sel) |=> flush_lgnt_n == !$past(xgnt))
    else $error("grant not routed");

  // ownership, width and routing checks not carried by the sequencer alone
  a_aen_dma: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && master_n && dma_act) |=> aen)
    else $error("aen low in dma transfer");
  a_one_ack: assert property (@(posedge mclk) disable iff (sys_rst)
    $onehot0(~dack_n))
    else $error("more than one acknowledge");
  a_tc_acked: assert property (@(posedge mclk) disable iff (sys_rst)
    tc |-> dack_n != '1)
    else $error("tc without acknowledge");
  a_narrow_ch: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && ch_q < 3'(`IDB_CH_CASCADE)) |=> !xfer_16bit)
    else $error("8-bit channel marked wide");
  a_io_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && ior_n_oe && iow_n_oe) |=> !io_rd_q && !io_wr_q)
    else $error("register access seen while driving");
  a_xreq_sel: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && !alt_sel) |=> !xreq)
    else $error("extra request with turbo selected");
  a_flush_route: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && !alt_sel) |=> flush_lgnt_n == $past(flush_w))
    else $error("flush not routed");
  c_dma: cover property (@(posedge mclk) st_q == IDB_ACK ##1 st_q == IDB_XFER);
  c_tc: cover property (@(posedge mclk) tc);
  c_master: cover property (@(posedge mclk) st_q == IDB_MSTR);
  c_flush: cover property (@(posedge mclk) !flush_lgnt_n && !alt_sel);
  c_refresh: cover property (@(posedge mclk) refresh_req && aen);
endmodule : idb_dma_sig

// ### src/idb_pkg.sv
// types for the isa dma bus signalling block
package idb_pkg;
  typedef enum logic [3:0] {
    IDB_IDLE = 4'b0001,
    IDB_ACK = 4'b0010,
    IDB_XFER = 4'b0100,
    IDB_MSTR = 4'b1000
  } idb_state_t;
  typedef enum logic [1:0] {
    IDB_OWN_CPU = 2'b00,
    IDB_OWN_DMA = 2'b01,
    IDB_OWN_REF = 2'b10,
    IDB_OWN_ISA = 2'b11
  } idb_owner_t;
endpackage : idb_pkg

// ### src/idb_regs.svh
// constants for the isa dma bus signalling block
`ifndef IDB_REGS_SVH
`define IDB_REGS_SVH
`define IDB_NCH 8
`define IDB_CH_CASCADE 4
`define IDB_HI_ADDR_W 4
`define IDB_CNT_W 16
`define IDB_FLUSH_PULSE_NS 80
`define IDB_CLK_PERIOD_NS 40
`define IDB_FLUSH_CYC ((`IDB_FLUSH_PULSE_NS + `IDB_CLK_PERIOD_NS - 1) / `IDB_CLK_PERIOD_NS)
`endif

// ### src/idb_speed.sv
// turbo and flush handling on the shared pins
`timescale 1ns/1ps
`include "idb_regs.svh"
module idb_speed
  import idb_pkg::*;
(
  // clock
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // configuration
  input wire logic alt_sel,
  input wire logic perf_cfg_done,
  input wire logic flush_en,
  // turbo and hold
  input wire logic slow_in,
  input wire logic perf_hold,
  // results
  output logic slow_req,
  output logic flush_n
);
  logic hold_q;
  logic [3:0] fcnt_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slow_req <= 1'b0;
    end else if (clk_en) begin
      // ignored until performance control is programmed
      slow_req <= !alt_sel && perf_cfg_done && !slow_in;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hold_q <= 1'b0;
    end else if (clk_en) begin
      hold_q <= perf_hold;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fcnt_q <= 4'h0;
      flush_n <= 1'b1;
    end else if (clk_en) begin
      if (!alt_sel && flush_en && perf_hold && !hold_q) begin
        fcnt_q <= 4'(`IDB_FLUSH_CYC);
        flush_n <= 1'b0;
      end else if (fcnt_q > 4'h1) begin
        fcnt_q <= fcnt_q - 4'h1;
      end else begin
        fcnt_q <= 4'h0;
        flush_n <= 1'b1;
      end
    end
  end
  a_slow_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && !perf_cfg_done) |=> !slow_req)
    else $error("turbo input not ignored");
  a_flush_start: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && !alt_sel && flush_en && perf_hold && !hold_q) |=> !flush_n)
    else $error("flush not issued on hold");
endmodule : idb_speed

// ### src/idb_strobe.sv
// low-megabyte memory strobe generation
`timescale 1ns/1ps
module idb_strobe
  import idb_pkg::*;
(
  // clock
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // sources
  input wire logic [3:0] hi_addr,
  input wire logic memw_n,
  input wire logic memr_n,
  // strobes
  output logic smemw_n,
  output logic smemr_n
);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      smemw_n <= 1'b1;
    end else if (clk_en) begin
      smemw_n <= ~((hi_addr == 4'h0) && !memw_n);
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      smemr_n <= 1'b1;
    end else if (clk_en) begin
      smemr_n <= ~((hi_addr == 4'h0) && !memr_n);
    end
  end
  a_smemw_low: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en |=> smemw_n == !($past(hi_addr) == 4'h0 && !$past(memw_n)))
    else $error("low memory write strobe wrong");
  a_smemr_low: assert property (@(posedge mclk) disable iff (sys_rst)
    clk_en |=> smemr_n == !($past(hi_addr) == 4'h0 && !$past(memr_n)))
    else $error("low memory read strobe wrong");
endmodule : idb_strobe

// ### test/idb_isa_dev.sv
// isa dma device and isa master model on the far side of the channels
`timescale 1ns/1ps
module idb_isa_dev (
  // clock
  input wire logic mclk,
  // control from the bench
  input wire logic req_on,
  input wire logic [2:0] ch,
  input wire logic as_master,
  // channel pins
  input wire logic [7:0] dack_n,
  input wire logic tc,
  output logic [7:0] dreq,
  output logic master_n
);
  logic done_q;
  initial begin
    done_q = 1'b0;
    master_n = 1'b1;
  end
  // a dma device lets go of its request once it has seen the final cycle or when req_on drops, a master only when req_on drops;
  // sampled on the edge like the design, so bench changes just after it never race
  always @(posedge mclk) begin
    if (!req_on) done_q <= 1'b0;
    else if (tc && !dack_n[ch] && !as_master) done_q <= 1'b1;
    master_n <= !(req_on && as_master && !dack_n[ch]);
  end
  assign dreq = (req_on && !done_q) ? (8'h01 << ch) : 8'h00;
endmodule : idb_isa_dev

// ### test/tb.sv
// self-checking bench for the isa dma bus signalling block
`timescale 1ns/1ps
module tb;
  logic mclk = 0, sys_rst = 1, alt_sel = 0, cfg = 0, flush_en = 0, refresh_req = 0;
  logic perf_hold = 0, slow_lreq_n = 1, xgnt = 0, dir_rd = 0, req_on = 0, as_m = 0;
  logic ior_d = 1, iow_d = 1, memr_d = 1, memw_d = 1, ce = 1;
  logic [2:0] ch = 0;
  logic [3:0] hi_addr = 4'h0;
  logic [15:0] xcnt = 16'h0002;
  logic [7:0] dreq, dack_n;
  logic tc, aen, x16, master_n, slow_req, flg_n, xreq, smemr_n, smemw_n, io_rd, io_wr;
  logic ior_o, ior_oe, iow_o, iow_oe, memr_o, memr_oe, memw_o, memw_oe;
  int bad_count = 0, n_checks = 0;
  // each strobe wire is whoever drives it, else the bench's value
  wire ior_w = ior_oe ? ior_o : ior_d;
  wire iow_w = iow_oe ? iow_o : iow_d;
  wire memr_w = memr_oe ? memr_o : memr_d;
  wire memw_w = memw_oe ? memw_o : memw_d;
  always #20 mclk = !mclk;

  idb_dma_sig i_idb_dma_sig (.mclk(mclk), .sys_rst(sys_rst), .clk_en(ce), .alt_sel(alt_sel),
    .perf_cfg_done(cfg), .flush_en(flush_en), .xfer_count(xcnt), .dreq(dreq),
    .dack_n(dack_n), .tc(tc), .aen(aen), .xfer_16bit(x16), .master_n(master_n),
    .refresh_req(refresh_req), .perf_hold(perf_hold), .slow_req(slow_req),
    .slow_lreq_n(slow_lreq_n), .flush_lgnt_n(flg_n), .xreq(xreq), .xgnt(xgnt),
    .ior_n_i(ior_w), .ior_n_o(ior_o), .ior_n_oe(ior_oe), .iow_n_i(iow_w), .iow_n_o(iow_o),
    .iow_n_oe(iow_oe), .memr_n_i(memr_w), .memr_n_o(memr_o), .memr_n_oe(memr_oe),
    .memw_n_i(memw_w), .memw_n_o(memw_o), .memw_n_oe(memw_oe), .hi_addr(hi_addr),
    .smemr_n(smemr_n), .smemw_n(smemw_n), .io_rd_q(io_rd), .io_wr_q(io_wr), .dir_rd(dir_rd));

  idb_isa_dev i_idb_isa_dev (.mclk(mclk), .req_on(req_on), .ch(ch), .as_master(as_m),
    .dack_n(dack_n), .tc(tc), .dreq(dreq), .master_n(master_n));

  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // sel 0: acknowledge low, 1: terminal count high, 2: acknowledge high
  function automatic logic hit(input int sel);
    return sel == 0 ? dack_n[ch] === 1'b0 : sel == 1 ? tc === 1'b1 : dack_n[ch] === 1'b1;
  endfunction : hit

  task wait_for(input int sel);
    int i;
    for (i = 0; i < 30 && !hit(sel); i++) cyc(1);
    if (!hit(sel)) begin
      bad_count++;
      $display("[FAIL] wait %0d timed out", sel);
      results();
    end
  endtask : wait_for

  task t_reset;
    chk("dack_n", dack_n, 8'hff);
    chk("aen tc", {aen, tc}, 2'b00);
    chk("oe", {ior_oe, iow_oe, memr_oe, memw_oe}, 4'h0);
  endtask : t_reset

  task t_channel(input int k);
    ch = k[2:0];
    dir_rd = k[0];
    req_on = 1;
    wait_for(0);
    chk("aen dma", aen, 1'b1);
    chk("width", x16, k > 4);
    cyc(1);
    chk("io oe", ior_oe | iow_oe, 1'b1);
    chk("mem oe", memr_oe | memw_oe, 1'b1);
    chk("dma strobes", {ior_o, iow_o, memr_o, memw_o}, k[0] ? 4'h9 : 4'h6);
    wait_for(1);
    chk("ack at tc", dack_n[ch], 1'b0);
    chk("dma smem", {smemr_n, smemw_n}, k[0] ? 2'b01 : 2'b10);
    chk("no io reg", {io_rd, io_wr}, 2'b00);
    wait_for(2);
    cyc(1);
    chk("after", {aen, tc, ior_oe, memw_oe, dack_n}, 12'h0ff);
    req_on = 0;
    cyc(1);
  endtask : t_channel

  task t_cascade;
    ch = 3'd4;
    req_on = 1;
    cyc(6);
    chk("cascade", dack_n, 8'hff);
    req_on = 0;
    cyc(1);
  endtask : t_cascade

  task t_master;
    ch = 3'd5;
    as_m = 1;
    req_on = 1;
    wait_for(0);
    cyc(3);
    chk("aen master", {aen, dack_n[5]}, 2'b00);
    req_on = 0;
    as_m = 0;
    cyc(3);
    chk("released", dack_n, 8'hff);
  endtask : t_master

  task t_refresh;
    refresh_req = 1;
    cyc(3);
    chk("aen refresh", {aen, dack_n}, 9'h1ff);
    refresh_req = 0;
    cyc(3);
    chk("aen cpu", aen, 1'b0);
  endtask : t_refresh

  // with the enable low nothing may move, even a refresh request
  task t_freeze;
    ce = 0;
    refresh_req = 1;
    cyc(3);
    chk("frozen aen", aen, 1'b0);
    ce = 1;
    cyc(1);
    chk("thawed aen", aen, 1'b1);
    refresh_req = 0;
    cyc(2);
  endtask : t_freeze

  task t_strobes;
    logic [3:0] a;
    for (int j = 0; j < 3; j++) begin
      a = (j == 0) ? 4'h0 : (j == 1) ? 4'h1 : 4'h8;
      hi_addr = a;
      memr_d = 0;
      cyc(2);
      chk("smemr", {smemr_n, smemw_n}, {a != 4'h0, 1'b1});
      memr_d = 1;
      memw_d = 0;
      cyc(2);
      chk("smemw", {smemr_n, smemw_n}, {1'b1, a != 4'h0});
      memw_d = 1;
    end
    ior_d = 0;
    cyc(3);
    chk("io read", io_rd, 1'b1);
    ior_d = 1;
    iow_d = 0;
    cyc(3);
    chk("io write", io_wr, 1'b1);
    iow_d = 1;
  endtask : t_strobes

  task t_speed;
    int lows;
    slow_lreq_n = 0;
    cyc(3);
    chk("slow unset", slow_req, 1'b0);
    cfg = 1;
    cyc(3);
    chk("slow", slow_req, 1'b1);
    slow_lreq_n = 1;
    cyc(3);
    chk("fast", slow_req, 1'b0);
    perf_hold = 1;
    cyc(3);
    chk("no flush", flg_n, 1'b1);
    perf_hold = 0;
    cyc(1);
    flush_en = 1;
    perf_hold = 1;
    lows = 0;
    repeat (8) begin
      cyc(1);
      lows += !flg_n;
    end
    chk("flush cycles", lows, 2);
    perf_hold = 0;
  endtask : t_speed

  task t_alt;
    alt_sel = 1;
    slow_lreq_n = 0;
    cyc(3);
    chk("xreq", {xreq, slow_req}, 2'b10);
    xgnt = 1;
    cyc(3);
    chk("grant", flg_n, 1'b0);
    xgnt = 0;
    slow_lreq_n = 1;
    cyc(3);
    chk("idle", {xreq, flg_n}, 2'b01);
  endtask : t_alt

  initial begin
    cyc(12);
    sys_rst = 0;
    t_reset();
    for (int k = 0; k < 8; k++) if (k != 4) t_channel(k);
    t_cascade();
    t_master();
    t_refresh();
    t_freeze();
    t_strobes();
    t_speed();
    t_alt();
    results();
  end
endmodule : tb
